// >>> include/scb_pkg.sv
package scb_pkg;

  // ----------------------------------------------------------------
  // Serial frame geometry
  // ----------------------------------------------------------------
  localparam int SERIAL_BITS = 20;
  localparam int FRAME_SLOTS = 32;
  localparam int SLOT_W = 5;
  localparam int SCLK_PER_MCLK = 4;
  localparam int LRCK_PER_SCLK = 64;

  // ----------------------------------------------------------------
  // Build defaults
  // ----------------------------------------------------------------
  localparam int DEFAULT_DIVISOR = 2;
  localparam int DEFAULT_SAMPLE_WIDTH = 20;
  localparam int DIV_CNT_W = 16;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADC_LEFT = 8'h08;
  localparam logic [7:0] REG_ADC_RIGHT = 8'h0C;
  localparam logic [7:0] REG_DAC_LEFT = 8'h10;
  localparam logic [7:0] REG_DAC_RIGHT = 8'h14;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_MUTE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int STAT_LEFT_BIT = 0;
  localparam int STAT_ADC_RDY_BIT = 1;
  localparam int STAT_DAC_RDY_BIT = 2;

  typedef enum logic [2:0] {
    SCB_IDLE = 3'b001,
    SCB_RUN = 3'b010,
    SCB_HOLD = 3'b100
  } scb_state_t;

endpackage

// >>> core/scb_clkgen.sv
// ------------------------------------------------------------------
// Divider chain: main clock to master, bit and channel clocks
// ------------------------------------------------------------------
module scb_clkgen #(
  parameter int DIVISOR = scb_pkg::DEFAULT_DIVISOR
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic mclk_level,
  output logic sclk_level,
  output logic sclk_fall,
  output logic sclk_rise,
  output logic lrck_level,
  output logic [scb_pkg::SLOT_W-1:0] slot
);
  import scb_pkg::*;

  localparam int HALF = (DIVISOR / 2 < 1) ? 1 : DIVISOR / 2;
  localparam logic [DIV_CNT_W-1:0] HALF_M1 = DIV_CNT_W'(HALF - 1);

  typedef struct packed {
    logic [DIV_CNT_W-1:0] div;
    logic mclk;
    logic [1:0] mph;
    logic sclk;
    logic [SLOT_W-1:0] slot;
    logic lrck;
    logic fall;
    logic rise;
  } scb_clk_t;

  scb_clk_t st;
  scb_clk_t next_st;

  always_comb begin
    next_st = st;
    next_st.fall = 1'b0;
    next_st.rise = 1'b0;
    if (!run) begin
      next_st = '0;
      next_st.lrck = 1'b1;
    end else if (st.div == HALF_M1) begin
      next_st.div = '0;
      next_st.mclk = ~st.mclk;
      // sclk toggles on every second mclk fall, so each sclk half-period spans
      // two full mclk periods (four mclk half-periods), giving mclk/4.
      if (st.mclk) begin
        next_st.mph = st.mph + 2'd1;
        if (st.mph[0]) begin
          next_st.sclk = ~st.sclk;
          if (st.sclk) begin
            next_st.fall = 1'b1;
            next_st.slot = st.slot + 1'b1;
            // Left high for 32 bit clocks, right low for 32: lrck = sclk/64.
            if (st.slot == SLOT_W'(FRAME_SLOTS - 1)) begin
              next_st.lrck = ~st.lrck;
            end
          end else begin
            next_st.rise = 1'b1;
          end
        end
      end
    end else begin
      next_st.div = st.div + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.lrck <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign mclk_level = st.mclk;
  assign sclk_level = st.sclk;
  assign sclk_fall = st.fall;
  assign sclk_rise = st.rise;
  assign lrck_level = st.lrck;
  assign slot = st.slot;

endmodule

// >>> core/scb_shifter.sv
// ------------------------------------------------------------------
// Host-width serial shifter for one direction pair
// ------------------------------------------------------------------
module scb_shifter #(
  parameter int WIDTH = scb_pkg::DEFAULT_SAMPLE_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_data,
  input wire logic shift_out,
  input wire logic shift_in,
  input wire logic serial_in,
  output logic serial_out,
  output logic [WIDTH-1:0] captured
);
  import scb_pkg::*;

  // Shift registers sized by host width; serial length stays twenty.
  typedef struct packed {
    logic [WIDTH-1:0] tx;
    logic [WIDTH-1:0] rx;
    logic [SLOT_W-1:0] tcnt;
    logic [SLOT_W-1:0] rcnt;
  } scb_shf_t;

  scb_shf_t st;
  scb_shf_t next_st;

  always_comb begin
    next_st = st;
    if (load) begin
      next_st.tx = load_data;
      next_st.tcnt = '0;
      next_st.rcnt = '0;
    end else if (shift_out) begin
      // Past the host width, zeros fill the remaining serial slots.
      next_st.tx = {st.tx[WIDTH-2:0], 1'b0};
      next_st.tcnt = st.tcnt + 1'b1;
    end
    // Only the first WIDTH bits of a frame are kept, so a narrow host
    // width drops the low-order tail of the twenty.
    if (shift_in && (st.rcnt < SLOT_W'(WIDTH))) begin
      next_st.rx = {st.rx[WIDTH-2:0], serial_in};
      next_st.rcnt = st.rcnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign serial_out = (st.tcnt < SLOT_W'(WIDTH)) ? st.tx[WIDTH-1] : 1'b0;
  assign captured = st.rx;

endmodule

// >>> core/scb_bridge.sv
// What this block does
// - ADC serial bits gather into a shift register, presented in parallel.
// - Host DAC sample is serialized as a twenty-bit transmission.
// - Variant A inverts codec outputs; variant C moves the DAC slots late; B and D change nothing.
// - Master clock equals main clock divided by the divisor parameter.
// - Host width sets bus and shifter widths; serial transfers stay twenty bits.
// - Active-low reset sets all state asynchronously; enable, left channel and lrck come up high.
// - Channel indicator high for left, low for right.
// - ADC ready rises after all bits received; ADC bus valid meanwhile.
// - DAC ready requests a sample; loaded on the next clock edge.
// - Bit clock runs at one quarter of master clock.
// - Channel clock high left, low right, bit clock over 64.
// - Variants A, B, D send DAC MSB first in first twenty slots.
// - Variant C sends DAC MSB first in last twenty slots.
// - ADC sample received MSB first from first twenty slots.
// - ADC and DAC of one channel share the same frame.
// - After left channel, the identical sequence repeats for right.
module scb_bridge #(
  parameter bit variant_a_inverted_outputs = 1'b0,
  parameter bit variant_b_timing = 1'b0,
  parameter bit variant_c_late_slot = 1'b0,
  parameter bit variant_d_timing = 1'b0,
  parameter int DIVISOR = scb_pkg::DEFAULT_DIVISOR,
  parameter int host_sample_width = scb_pkg::DEFAULT_SAMPLE_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic left_chan,
  output logic [host_sample_width-1:0] adc_data,
  output logic adc_rdy,
  input wire logic [host_sample_width-1:0] dac_data,
  output logic dac_rdy,
  output logic mclk,
  output logic sclk,
  output logic lrck,
  output logic sdti,
  input wire logic sdto
);
  import scb_pkg::*;

  // Short alias for the host width; every internal host-width vector uses it, the ports use host_sample_width.
  localparam int W = host_sample_width;
  localparam logic [SLOT_W-1:0] LATE_FIRST = SLOT_W'(FRAME_SLOTS - SERIAL_BITS);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] zext(input logic [W-1:0] v);
    logic [31:0] r;
    r = '0;
    r[W-1:0] = v;
    return r;
  endfunction

  function automatic logic in_window(input logic [SLOT_W-1:0] s, input logic late);
    logic r;
    if (late) begin
      r = (s >= SLOT_W'(FRAME_SLOTS - SERIAL_BITS));
    end else begin
      r = (s < SLOT_W'(SERIAL_BITS));
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    scb_state_t fsm;
    logic [1:0] ctrl;
    logic chan_left;
    logic adc_rdy;
    logic dac_rdy;
    logic [W-1:0] adc_out;
    // The last word of each channel stays readable for software.
    logic [W-1:0] adc_left;
    logic [W-1:0] adc_right;
    logic [W-1:0] sw_dac_left;
    logic [W-1:0] sw_dac_right;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic sdti;
  } scb_top_t;

  scb_top_t st;
  scb_top_t next_st;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Both the answer phase and the commit edge need to know whether an
  // offset is mapped, so the test lives in one place.
  function automatic logic addr_known(input logic [7:0] a);
    logic r;
    case (a)
      REG_CTRL, REG_STATUS, REG_ADC_LEFT, REG_ADC_RIGHT: begin
        r = 1'b1;
      end
      REG_DAC_LEFT, REG_DAC_RIGHT: begin
        r = 1'b1;
      end
      default: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction

  // Unmapped offsets read as zero; the error flag tells the master.
  function automatic logic [31:0] read_word(input scb_top_t s, input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    case (a)
      REG_CTRL: begin
        r[1:0] = s.ctrl;
      end
      REG_STATUS: begin
        r[STAT_LEFT_BIT] = s.chan_left;
        r[STAT_ADC_RDY_BIT] = s.adc_rdy;
        r[STAT_DAC_RDY_BIT] = s.dac_rdy;
      end
      REG_ADC_LEFT: begin
        r = zext(s.adc_left);
      end
      REG_ADC_RIGHT: begin
        r = zext(s.adc_right);
      end
      REG_DAC_LEFT: begin
        r = zext(s.sw_dac_left);
      end
      REG_DAC_RIGHT: begin
        r = zext(s.sw_dac_right);
      end
      default: begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  logic mclk_i;
  logic sclk_i;
  logic sclk_fall;
  logic sclk_rise;
  logic lrck_i;
  logic [SLOT_W-1:0] slot;
  logic tx_bit;
  logic [W-1:0] rx_word;
  logic load;
  logic shift_out;
  logic shift_in;
  logic [W-1:0] dac_word;
  logic frame_start;
  logic apb_access;
  logic [SLOT_W-1:0] tx_first;

  // ----------------------------------------------------------------
  // Clock generation and shifter
  // ----------------------------------------------------------------
  scb_clkgen #(
    .DIVISOR(DIVISOR)
  ) u_clk (
    .pclk(pclk),
    .presetn(presetn),
    .run(st.ctrl[CTRL_ENABLE_BIT]),
    .mclk_level(mclk_i),
    .sclk_level(sclk_i),
    .sclk_fall(sclk_fall),
    .sclk_rise(sclk_rise),
    .lrck_level(lrck_i),
    .slot(slot)
  );

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  // The frame boundary is the sclk fall where the slot counter wraps.
  assign frame_start = sclk_fall && (slot == '0);
  // Request one cycle before the shifter takes the sample.
  assign load = st.dac_rdy;
  // The MSB is already on the line when the window opens, so the shifter
  // advances only on the later falls of the window; shifting on the
  // opening fall as well would lose the MSB.
  assign tx_first = variant_c_late_slot ? LATE_FIRST : '0;
  assign shift_out = sclk_fall && (slot != tx_first) &&
    in_window(slot, variant_c_late_slot);
  // Input bits are sampled on sclk rise in the first twenty slots.
  assign shift_in = sclk_rise && in_window(slot, 1'b0);
  // Host and software sources are ORed; mute wins over both.
  assign dac_word = st.ctrl[CTRL_MUTE_BIT] ? '0 :
    (dac_data | (st.chan_left ? st.sw_dac_left : st.sw_dac_right));

  // The shifter works on host-width words; the slot counter alone bounds
  // each transfer to twenty bits.
  scb_shifter #(
    .WIDTH(W)
  ) u_shf (
    .pclk(pclk),
    .presetn(presetn),
    .load(load),
    .load_data(dac_word),
    .shift_out(shift_out),
    .shift_in(shift_in),
    .serial_in(sdto),
    .serial_out(tx_bit),
    .captured(rx_word)
  );

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  assign apb_access = psel && penable;

  // ----------------------------------------------------------------
  // Sequencer and register file
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.adc_rdy = 1'b0;
    next_st.dac_rdy = 1'b0;
    next_st.ready = 1'b0;
    // Late window: the line stays low until the window opens, while the
    // loaded MSB waits at the head of the shift register.
    next_st.sdti = (variant_c_late_slot && slot < LATE_FIRST) ? 1'b0 : tx_bit;
    case (st.fsm)
      SCB_IDLE: begin
        // A fresh start always begins with the left channel.
        if (st.ctrl[CTRL_ENABLE_BIT]) begin
          next_st.fsm = SCB_RUN;
          next_st.chan_left = 1'b1;
          next_st.dac_rdy = 1'b1;
        end
      end
      SCB_RUN: begin
        // After the twentieth input bit the ADC word is final.
        // The capture waits one fall past the last rise, so the word is settled.
        if (sclk_fall && slot == SLOT_W'(SERIAL_BITS)) begin
          next_st.adc_out = rx_word;
          next_st.adc_rdy = 1'b1;
          if (st.chan_left) begin
            next_st.adc_left = rx_word;
          end else begin
            next_st.adc_right = rx_word;
          end
          next_st.fsm = SCB_HOLD;
        end
      end
      SCB_HOLD: begin
        if (frame_start) begin
          // Left then right, same sequence each time.
          next_st.chan_left = ~st.chan_left;
          next_st.dac_rdy = 1'b1;
          next_st.fsm = SCB_RUN;
        end
      end
      default: begin
        next_st.fsm = SCB_IDLE;
      end
    endcase
    // Clearing the enable bit drops the sequencer to idle at once; the
    // divider chain is held in its rest phase by the same bit.
    if (!st.ctrl[CTRL_ENABLE_BIT]) begin
      next_st.fsm = SCB_IDLE;
      next_st.chan_left = 1'b1;
    end
    // One wait state: the answer is decoded in the access phase and shows
    // a cycle later; a write lands only on the edge that completes the
    // transfer, so a stalled access phase never commits early.
    if (apb_access && !st.ready) begin
      next_st.ready = 1'b1;
      next_st.err = ~addr_known(paddr);
      next_st.rdata = read_word(st, paddr);
    end
    if (apb_access && st.ready && pwrite && addr_known(paddr)) begin
      case (paddr)
        REG_CTRL: begin
          next_st.ctrl = pwdata[1:0];
        end
        REG_DAC_LEFT: begin
          next_st.sw_dac_left = pwdata[W-1:0];
        end
        REG_DAC_RIGHT: begin
          next_st.sw_dac_right = pwdata[W-1:0];
        end
        default: begin
          next_st.ctrl = st.ctrl;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.fsm <= SCB_IDLE;
      // Enable comes up set so the codec is clocked without software.
      st.ctrl <= CTRL_RESET;
      st.chan_left <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Read data and the error flag come from flops, so the bus sees no
  // path from the address decode straight back to its inputs.
  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.ready & st.err;
  // Host strobes are single-cycle pulses; the host must catch them on the
  // edge that follows.
  assign left_chan = st.chan_left;
  assign adc_data = st.adc_out;
  assign adc_rdy = st.adc_rdy;
  assign dac_rdy = st.dac_rdy;

  // ----------------------------------------------------------------
  // Codec pins
  // ----------------------------------------------------------------
  // Variant A board sits behind inverting buffers; B and D need no change.
  assign mclk = mclk_i ^ variant_a_inverted_outputs;
  assign sclk = sclk_i ^ variant_a_inverted_outputs;
  assign lrck = lrck_i ^ variant_a_inverted_outputs;
  assign sdti = st.sdti ^ variant_a_inverted_outputs;

endmodule

// >>> bench/scb_bridge_props.sv
module scb_bridge_props #(
  parameter int DIVISOR = 2,
  parameter int host_sample_width = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic left_chan,
  input wire logic [host_sample_width-1:0] adc_data,
  input wire logic adc_rdy,
  input wire logic dac_rdy,
  input wire logic mclk,
  input wire logic sclk,
  input wire logic lrck
);
  logic [15:0] cm, cs, cl;
  logic sm, ss, sl, sd, last_ch;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The seen flags skip the first level change, whose phase reset decides.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cm <= 16'h0000;
      cs <= 16'h0000;
      cl <= 16'h0000;
      {sm, ss, sl, sd, last_ch} <= 5'h00;
    end else begin
      cm <= $changed(mclk) ? 16'h0000 : cm + 16'h0001;
      cs <= $changed(sclk) ? 16'h0000 : cs + 16'h0001;
      cl <= $changed(lrck) ? 16'h0000 : cl + 16'h0001;
      sm <= sm | $changed(mclk);
      ss <= ss | $changed(sclk);
      sl <= sl | $changed(lrck);
      sd <= sd | dac_rdy;
      last_ch <= dac_rdy ? left_chan : last_ch;
    end
  end
  property p_mclk;
    $changed(mclk) && sm |-> cm == 16'(DIVISOR / 2 - 1);
  endproperty
  a_mclk: assert property (p_mclk) else $error("mclk half period wrong");
  property p_sclk;
    $changed(sclk) && ss |-> cs == 16'(2 * DIVISOR - 1);
  endproperty
  a_sclk: assert property (p_sclk) else $error("sclk half period wrong");
  property p_lrck;
    $changed(lrck) && sl |-> cl == 16'(128 * DIVISOR - 1);
  endproperty
  a_lrck: assert property (p_lrck) else $error("lrck half period wrong");
  property p_adc_pulse;
    adc_rdy |=> !adc_rdy;
  endproperty
  a_adc_pulse: assert property (p_adc_pulse) else $error("adc_rdy too long");
  property p_adc_hold;
    !adc_rdy |-> $stable(adc_data);
  endproperty
  a_adc_hold: assert property (p_adc_hold) else $error("adc_data moved");
  property p_chan_alt;
    dac_rdy && sd |-> left_chan != last_ch;
  endproperty
  a_chan_alt: assert property (p_chan_alt) else $error("channel repeated");
  property p_frame;
    dac_rdy |-> ##[1:256] adc_rdy;
  endproperty
  a_frame: assert property (p_frame) else $error("no adc_rdy in frame");
  property p_apb_ans;
    psel && penable && !pready |=> pready;
  endproperty
  a_apb_ans: assert property (p_apb_ans) else $error("pready late");
  property p_slverr;
    pslverr |-> pready;
  endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr alone");
  c_left: cover property (adc_rdy && left_chan);
  c_right: cover property (adc_rdy && !left_chan);
  c_err: cover property (pslverr);
endmodule

bind scb_bridge scb_bridge_props #(
  .DIVISOR(DIVISOR),
  .host_sample_width(host_sample_width)
) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .left_chan(left_chan),
  .adc_data(adc_data), .adc_rdy(adc_rdy), .dac_rdy(dac_rdy),
  .mclk(mclk), .sclk(sclk), .lrck(lrck)
);

// >>> bench/scb_codec_model.sv
module scb_codec_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic lrck,
  input wire logic sdti,
  output logic sdto,
  input wire logic [19:0] adc_l,
  input wire logic [19:0] adc_r,
  output logic rx_done,
  output logic rx_left,
  output logic [19:0] rx_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sclk_q, lrck_q;
  logic [5:0] tx_idx, rx_idx;
  logic [19:0] word;
  assign word = lrck ? adc_l : adc_r;
  // Past the sample the line toggles, so a late sample never reads stale data.
  assign sdto = (tx_idx < 6'd20) ? word[5'd19 - tx_idx[4:0]] : tx_idx[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sclk_q, lrck_q, rx_done, rx_left} <= 4'h4;
      {tx_idx, rx_idx} <= 12'h000;
      rx_word <= 20'h00000;
    end else begin
      sclk_q <= sclk;
      lrck_q <= lrck;
      rx_done <= 1'b0;
      if (lrck != lrck_q) begin
        tx_idx <= 6'd0;
        rx_idx <= 6'd0;
      end else if (!sclk && sclk_q) begin
        tx_idx <= tx_idx + 6'd1;
      end else if (sclk && !sclk_q && rx_idx < 6'd20) begin
        rx_word <= {rx_word[18:0], sdti};
        rx_idx <= rx_idx + 6'd1;
        rx_done <= (rx_idx == 6'd19);
        rx_left <= lrck;
      end
    end
  end
endmodule

// >>> bench/scb_bridge_tb.sv
module scb_bridge_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import scb_pkg::*;
  localparam int W = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic left_chan, adc_rdy, dac_rdy, mclk, sclk, lrck, sdti, sdto;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, sw_val;
  logic [W-1:0] adc_data, dac_data, left_exp;
  logic [19:0] adc_l, adc_r, rx_word;
  logic [19:0] exp_dac [2];
  logic rx_done, rx_left, er;
  int err_total, cmp_count, frames, cyc;
  integer seed;
  // Divisor kept a power of two; one board variant at most, here none.
  // Divisor 2 on a 20 MHz main clock puts the master clock at 10 MHz.
  scb_bridge #(.DIVISOR(2), .host_sample_width(W)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .left_chan(left_chan),
    .adc_data(adc_data), .adc_rdy(adc_rdy), .dac_data(dac_data),
    .dac_rdy(dac_rdy), .mclk(mclk), .sclk(sclk), .lrck(lrck),
    .sdti(sdti), .sdto(sdto));
  scb_codec_model i_codec (.pclk(pclk), .presetn(presetn), .sclk(sclk),
    .lrck(lrck), .sdti(sdti), .sdto(sdto), .adc_l(adc_l), .adc_r(adc_r),
    .rx_done(rx_done), .rx_left(rx_left), .rx_word(rx_word));
  always #25 pclk = ~pclk;
  function automatic logic [19:0] pad(input logic [W-1:0] d);
    return {d, {(20 - W){1'b0}}};
  endfunction
  function automatic logic [W-1:0] cut(input logic [19:0] a);
    return a[19 -: W];
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_frames(input int n);
    int t;
    t = frames + n;
    while (frames < t) @(posedge pclk);
  endtask
  // ----------------------------------------------------------------
  // Host side and serial monitor
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
    if (presetn && dac_rdy) begin
      exp_dac[left_chan] <= pad(dac_data);
      dac_data <= W'($random(seed));
    end
    if (presetn && adc_rdy) begin
      check("adc_data", adc_data, cut(left_chan ? adc_l : adc_r));
      if (left_chan) left_exp <= cut(adc_l);
      if (left_chan) adc_l <= 20'($random(seed));
      else adc_r <= 20'($random(seed));
    end
    if (rx_done) begin
      check("serial_dac", rx_word, exp_dac[rx_left]);
      check("left_chan", left_chan, rx_left);
      frames++;
    end
  end
  initial begin
    {pclk, psel, penable, pwrite, presetn} = 5'h00;
    {paddr, pwdata} = '0;
    {err_total, cmp_count, frames, cyc} = '0;
    seed = 76;
    dac_data = 16'hFFFF;
    adc_l = 20'hFFFFF;
    adc_r = 20'h80001;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, REG_CTRL, 32'h0);
    check("ctrl", rd, 32'h00000001);
    apb(1'b1, REG_CTRL, 32'h00000001);
    apb(1'b0, 8'h40, 32'h0);
    check("pslverr", er, 1'b1);
    $display("test registers done");
    wait_frames(10);
    while (!(adc_rdy && left_chan)) @(posedge pclk);
    @(posedge pclk);
    apb(1'b0, REG_ADC_LEFT, 32'h0);
    check("adc_left_reg", rd, {16'h0000, left_exp});
    apb(1'b0, REG_STATUS, 32'h0);
    check("status", rd, 32'h00000001);
    sw_val = {16'h0000, 16'($random(seed))};
    apb(1'b1, REG_DAC_LEFT, sw_val);
    apb(1'b0, REG_DAC_LEFT, 32'h0);
    check("dac_left_reg", rd, sw_val);
    apb(1'b1, REG_DAC_LEFT, 32'h0);
    $display("test stream done");
    presetn <= 1'b0;
    #1;
    check("reset_outs", {left_chan, adc_rdy, dac_rdy, lrck}, 4'h9);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_frames(4);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
